/* design/pdc_pin_cell.sv */
// One port pin cell: drives the pin from its latch when the flag is set
`default_nettype none
module pdc_pin_cell
   import pdc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic dir_flag,
   input wire logic latch_val,
   output logic pin_out,
   output logic pin_oe_n
);
   typedef struct packed {
      logic out;
      logic oe_n;
   } pdc_cell_state_t;

   pdc_cell_state_t state_reg;
   pdc_cell_state_t state_next;

   always_comb begin
      state_next.out = latch_val;
      state_next.oe_n = ~dir_flag;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         state_reg <= state_next;
      end
   end

   assign pin_out = state_reg.out;
   assign pin_oe_n = state_reg.oe_n;

   chk_cell_oe_follows: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 (pin_oe_n == !$past(dir_flag)))
      else $error("pin enable does not follow direction flag");
endmodule : pdc_pin_cell
`default_nettype wire

/* design/pdc_pkg.sv */
// Package for the port direction control block
`default_nettype none
package pdc_pkg;
   localparam int unsigned PDC_ADDR_W = 12;
   localparam int unsigned PDC_DATA_W = 8;
   localparam logic [11:0] PDC_ADDR_GROUP_ONE = 12'hFE6;
   localparam logic [11:0] PDC_ADDR_GROUP_TWO = 12'hFE8;
   localparam logic [7:0] PDC_RESET_GROUP_ONE = 8'h00;
   localparam logic [7:0] PDC_RESET_GROUP_TWO = 8'h00;
   // Writable flag masks; bits outside read as fixed zero
   localparam logic [7:0] PDC_MASK_GROUP_ONE = 8'h7F;
   localparam logic [7:0] PDC_MASK_GROUP_TWO = 8'h0F;
   localparam int unsigned PDC_P0_LSB = 0;
   localparam int unsigned PDC_P2_LSB = 4;
   localparam int unsigned PDC_P3_LSB = 0;
   localparam int unsigned PDC_P0_PINS = 4;
   localparam int unsigned PDC_P2_PINS = 3;
   localparam int unsigned PDC_P3_PINS = 4;

   typedef struct packed {
      logic wr_en;
      logic [11:0] addr;
      logic [7:0] wdata;
   } pdc_wr_t;

   typedef struct packed {
      logic [3:0] port0;
      logic [2:0] port2;
      logic [3:0] port3;
   } pdc_pins_t;
endpackage : pdc_pkg
`default_nettype wire

/* design/pdc_port_dir.sv */
// Direction registers for ports 0, 2 and 3 and their pin drivers
//
// Notes on behaviour
// - Group-one bits 3..0 steer port 0 pins, bits 6..4 steer port 2 pins.
// - Group-two bit n steers port 3 pin n, for n 0 to 3.
// - Flag 0 makes the pin an input; flag 1 drives the output latch.
// - Writes to group two touch only port 3 directions.
// - Group-two bits 7..4 and group-one bit 7 stay zero regardless.
`default_nettype none
module pdc_port_dir
   import pdc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire pdc_wr_t wr,
   input wire pdc_pins_t latch,
   output pdc_pins_t pin_out,
   output pdc_pins_t pin_oe_n
);
   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] group_one;
      logic [7:0] group_two;
   } pdc_state_t;

   pdc_state_t state_reg;
   pdc_state_t state_next;

   always_comb begin
      state_next = state_reg;
      if (wr.wr_en && (wr.addr == PDC_ADDR_GROUP_ONE)) begin
         state_next.group_one = wr.wdata & PDC_MASK_GROUP_ONE;
      end
      if (wr.wr_en && (wr.addr == PDC_ADDR_GROUP_TWO)) begin
         state_next.group_two = wr.wdata & PDC_MASK_GROUP_TWO;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg.group_one <= PDC_RESET_GROUP_ONE;
         state_reg.group_two <= PDC_RESET_GROUP_TWO;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Pin cells
   // ------------------------------------------------------------
   pdc_pins_t dir;
   assign dir.port0 = state_reg.group_one[PDC_P0_LSB +: PDC_P0_PINS];
   assign dir.port2 = state_reg.group_one[PDC_P2_LSB +: PDC_P2_PINS];
   assign dir.port3 = state_reg.group_two[PDC_P3_LSB +: PDC_P3_PINS];

   localparam int unsigned NPINS = PDC_P0_PINS + PDC_P2_PINS + PDC_P3_PINS;
   logic [NPINS-1:0] dir_v;
   logic [NPINS-1:0] latch_v;
   logic [NPINS-1:0] out_v;
   logic [NPINS-1:0] oe_v;
   assign dir_v = dir;
   assign latch_v = latch;

   genvar i;
   generate
      for (i = 0; i < NPINS; i++) begin : g_pin
         pdc_pin_cell u_cell (
            .clk(clk),
            .reset_n(reset_n),
            .dir_flag(dir_v[i]),
            .latch_val(latch_v[i]),
            .pin_out(out_v[i]),
            .pin_oe_n(oe_v[i])
         );
      end
   endgenerate

   assign pin_out = out_v;
   assign pin_oe_n = oe_v;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_one_bit7_zero: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg.group_one & ~PDC_MASK_GROUP_ONE) == 8'h00)
      else $error("group one bit 7 not zero");

   chk_two_high_zero: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg.group_two & ~PDC_MASK_GROUP_TWO) == 8'h00)
      else $error("group two high bits not zero");

   chk_one_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_ONE) |=> ##1
      (pin_oe_n.port0 == ~$past(wr.wdata[3:0], 2)))
      else $error("port 0 direction wrong after write");

   chk_p2_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_ONE) |=> ##1
      (pin_oe_n.port2 == ~$past(wr.wdata[6:4], 2)))
      else $error("port 2 direction wrong after write");

   chk_two_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_TWO) |=> ##1
      (pin_oe_n.port3 == ~$past(wr.wdata[3:0], 2)))
      else $error("port 3 direction wrong after write");

   chk_two_isolated: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_TWO) |=>
      $stable(state_reg.group_one))
      else $error("group two write disturbed group one");

   chk_out_drive: assert property (@(posedge clk) disable iff (!reset_n)
      (state_reg.group_two[0]) |=> (!pin_oe_n.port3[0] && pin_out.port3[0] ==
      $past(latch.port3[0])))
      else $error("output pin not driving latch");

   chk_reset_inputs: assert property (@(posedge clk)
      $rose(reset_n) |-> (pin_oe_n == '1 && state_reg == '0))
      else $error("pins not inputs after reset");

   chk_reset_out_low: assert property (@(posedge clk)
      $rose(reset_n) |-> (pin_out == '0))
      else $error("pin outputs not low after reset");

   // ------------------------------------------------------------
   // Checks on register writes
   // ------------------------------------------------------------
   // Flags move only on a strobe aimed at their own address
   chk_idle_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !wr.wr_en |=> $stable(state_reg))
      else $error("flags changed without a write");

   chk_stray_ignored: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr != PDC_ADDR_GROUP_ONE && wr.addr != PDC_ADDR_GROUP_TWO)
      |=> $stable(state_reg))
      else $error("write to other address changed flags");

   chk_one_whole_byte: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_ONE) |=>
      (state_reg.group_one == ($past(wr.wdata) & PDC_MASK_GROUP_ONE)))
      else $error("group one not loaded with whole byte");

   chk_two_whole_byte: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_TWO) |=>
      (state_reg.group_two == ($past(wr.wdata) & PDC_MASK_GROUP_TWO)))
      else $error("group two not loaded with whole byte");

   // ------------------------------------------------------------
   // Checks on group isolation
   // ------------------------------------------------------------
   // Pin enables lag the flags by one edge, hence the extra cycle
   chk_one_isolated: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_ONE) |=>
      $stable(state_reg.group_two))
      else $error("group one write disturbed group two");

   chk_two_keeps_p0: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_TWO) |=> ##1
      $stable(pin_oe_n.port0))
      else $error("group two write moved port 0 direction");

   chk_two_keeps_p2: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_TWO) |=> ##1
      $stable(pin_oe_n.port2))
      else $error("group two write moved port 2 direction");

   chk_one_keeps_p3: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.wr_en && wr.addr == PDC_ADDR_GROUP_ONE) |=> ##1
      $stable(pin_oe_n.port3))
      else $error("group one write moved port 3 direction");

   // ------------------------------------------------------------
   // Checks on pin drivers
   // ------------------------------------------------------------
   // The first edge after reset still shows reset values, so skip it
   chk_out_follows: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |-> (pin_out == $past(latch)))
      else $error("pin outputs do not follow latch");

   chk_oe_follows: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |-> (pin_oe_n == ~$past(dir_v)))
      else $error("pin enables do not follow flags");

   chk_p0_map: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |->
      (pin_oe_n.port0 == ~$past(state_reg.group_one[PDC_P0_LSB +: PDC_P0_PINS])))
      else $error("port 0 enables not mapped to group one");

   chk_p2_map: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |->
      (pin_oe_n.port2 == ~$past(state_reg.group_one[PDC_P2_LSB +: PDC_P2_PINS])))
      else $error("port 2 enables not mapped to group one");

   chk_p3_map: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |->
      (pin_oe_n.port3 == ~$past(state_reg.group_two[PDC_P3_LSB +: PDC_P3_PINS])))
      else $error("port 3 enables not mapped to group two");

   chk_p0_drive: assert property (@(posedge clk) disable iff (!reset_n)
      state_reg.group_one[PDC_P0_LSB] |=> (!pin_oe_n.port0[0] &&
      pin_out.port0[0] == $past(latch.port0[0])))
      else $error("port 0 pin not driving latch");

   chk_p2_drive: assert property (@(posedge clk) disable iff (!reset_n)
      state_reg.group_one[PDC_P2_LSB] |=> (!pin_oe_n.port2[0] &&
      pin_out.port2[0] == $past(latch.port2[0])))
      else $error("port 2 pin not driving latch");

   chk_p0_release: assert property (@(posedge clk) disable iff (!reset_n)
      !state_reg.group_one[PDC_P0_LSB] |=> pin_oe_n.port0[0])
      else $error("port 0 pin driving while an input");

   chk_p2_release: assert property (@(posedge clk) disable iff (!reset_n)
      !state_reg.group_one[PDC_P2_LSB] |=> pin_oe_n.port2[0])
      else $error("port 2 pin driving while an input");

   chk_in_release: assert property (@(posedge clk) disable iff (!reset_n)
      !state_reg.group_two[PDC_P3_LSB] |=> pin_oe_n.port3[0])
      else $error("port 3 pin driving while an input");
endmodule : pdc_port_dir
`default_nettype wire

/* verification/pdc_pin_model.sv */
// Far-side pin model for ports 0, 2 and 3
`default_nettype none
module pdc_pin_model
   import pdc_pkg::*;
(
   input wire pdc_pins_t pin_out,
   input wire pdc_pins_t pin_oe_n,
   input wire pdc_pins_t ext,
   output wire pdc_pins_t level
);
   timeunit 1ns;
   timeprecision 1ps;
   // External source drives only pins whose port driver is off
   assign level = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule : pdc_pin_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench for the port direction block
`default_nettype none
module tb;
   import pdc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   pdc_wr_t wr = '0;
   pdc_pins_t latch = '0;
   pdc_pins_t ext = '0;
   pdc_pins_t pin_out, pin_oe_n, level, e;
   logic [7:0] g1 = 8'h00;
   logic [7:0] g2 = 8'h00;
   logic [31:0] seed = 32'h27C7;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   pdc_port_dir dut (.clk(clk), .reset_n(reset_n), .wr(wr), .latch(latch),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n));
   pdc_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .level(level));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic pdc_pins_t exp_oe(input logic [7:0] one, input logic [7:0] two);
      return ~{one[3:0], one[6:4], two[3:0]};
   endfunction : exp_oe
   task automatic check(input string what, input pdc_pins_t seen, input pdc_pins_t exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic write(input logic [11:0] a, input logic [7:0] d);
      wr <= '{1'b1, a, d};
      @(negedge clk);
      if (a == PDC_ADDR_GROUP_ONE) g1 = d & PDC_MASK_GROUP_ONE;
      if (a == PDC_ADDR_GROUP_TWO) g2 = d & PDC_MASK_GROUP_TWO;
   endtask : write
   task automatic look;
      wr.wr_en <= 1'b0;
      repeat (2) @(negedge clk);
      e = exp_oe(g1, g2);
      check("pin_oe_n", pin_oe_n, e);
      check("pin_out", pin_out, latch);
      check("pin_level", level, (latch & ~e) | (ext & e));
   endtask : look
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      repeat (3) @(negedge clk);
      check("oe_in_reset", pin_oe_n, '1);
      check("out_in_reset", pin_out, '0);
      reset_n <= 1'b1;
      write(PDC_ADDR_GROUP_ONE, 8'hFF);
      write(PDC_ADDR_GROUP_TWO, 8'hFF);
      look;
      write(PDC_ADDR_GROUP_ONE, 8'h80);
      write(PDC_ADDR_GROUP_TWO, 8'hF0);
      look;
      $display("Test fixed zero bits done");
      for (int i = 0; i < 200; i++) begin
         seed = lfsr(seed);
         latch <= seed[10:0];
         ext <= seed[21:11];
         case (seed[23:22])
            2'h0: write(PDC_ADDR_GROUP_ONE, seed[31:24]);
            2'h1: write(PDC_ADDR_GROUP_TWO, seed[31:24]);
            2'h2: write(seed[24] ? 12'hFE7 : 12'hFE9, seed[31:24]);
            default: begin
               write(PDC_ADDR_GROUP_TWO, seed[31:24]);
               write(PDC_ADDR_GROUP_ONE, {seed[27:24], seed[31:28]});
            end
         endcase
         look;
      end
      $display("Test random writes done");
      reset_n <= 1'b0;
      @(negedge clk);
      check("oe_mid_reset", pin_oe_n, '1);
      check("out_mid_reset", pin_out, '0);
      g1 = 8'h00;
      g2 = 8'h00;
      reset_n <= 1'b1;
      look;
      $display("Test mid-run reset done");
      wrap_up;
   end
endmodule : tb
`default_nettype wire
